// ==== logic/rcc_readout.sv ====
// charge counter readout for the first output rail, apb slave
// Functional notes
// - mode status bits 1:0 report the present converter mode
// - calibration holds the converter in its captured mode
// - mode status does not update while it is addressed
// - high counter byte at index 0x13, read-only, resets to zero
// - each count equals a prescaler-set number of converter pulses
// - counter spans two bytes and updates while converter runs
// - counter updating stops while a counter byte is addressed
// - reading high byte copies low byte into shadow
// - reading low byte returns the shadow value
// - low counter byte at index 0x14, read-only
// - command bit 5 clears all counter bytes
// - command bit 4 starts calibration
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rcc_readout #(
	parameter int CAL_CYCLES = rcc_pkg::CAL_CYCLES,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter side, asynchronous
	input wire logic [1:0] rail_a_converter_mode,
	input wire logic pfm_pulse,
	// mode hold to the converter
	output logic mode_hold,
	output logic [1:0] mode_hold_value
);

	// elaboration checks
	generate
		if (CAL_CYCLES < 1) begin : g_bad_cal
			$error("calibration window must be at least one cycle");
		end
		if (ADDR_W < 10) begin : g_bad_addr
			$error("address too narrow for the register map");
		end
		if (CAL_CYCLES / 2 > 65535) begin : g_bad_tally
			$error("calibration window too long for the pulse tally");
		end
	endgenerate

	// address match for one register index
	function automatic logic hits(input logic [ADDR_W-1:0] addr,
			input logic [7:0] idx);
		hits = (addr == ADDR_W'({idx, 2'b00}));
	endfunction : hits

	// one bit out of the write data
	function automatic logic wbit(input logic [31:0] data, input int pos);
		wbit = data[pos];
	endfunction : wbit

	// synchroniser stages
	logic [1:0] mode_meta_bus;
	logic [1:0] mode_sync;
	logic pulse_meta;
	logic pulse_sync;
	logic pulse_prev;
	logic pulse_edge;

	// register state
	logic [1:0] mode_status;
	logic [15:0] count;
	logic [7:0] shadow_low;
	logic [7:0] prescale_cnt;
	logic [7:0] prescale_div;
	logic [2:0] prescale_sel;

	// apb response
	logic ack_pending;
	logic [31:0] prdata_q;
	logic err_q;
	logic [31:0] next_prdata;
	logic next_err;
	logic xfer_done;
	logic rd_done;
	logic wr_done;

	// address decode
	logic at_mode;
	logic at_high;
	logic at_low;
	logic at_cmd;
	logic at_ctrl;
	logic at_cal;
	logic mapped;

	// freezes and strobes
	logic count_frozen;
	logic mode_frozen;
	logic clear_cmd;
	logic cal_start;
	logic count_tick;

	// calibration
	rcc_pkg::rcc_cal_state_e cal_state;
	logic [31:0] cal_timer;
	logic [15:0] cal_count;
	logic [1:0] cal_mode;
	logic cal_busy;

	// address decode
	assign at_mode = hits(paddr, rcc_pkg::MODE_IDX);
	assign at_high = hits(paddr, rcc_pkg::HIGH_IDX);
	assign at_low = hits(paddr, rcc_pkg::LOW_IDX);
	assign at_cmd = hits(paddr, rcc_pkg::CMD_IDX);
	assign at_ctrl = hits(paddr, rcc_pkg::CTRL_IDX);
	assign at_cal = hits(paddr, rcc_pkg::CAL_IDX);
	assign mapped = at_mode | at_high | at_low | at_cmd | at_ctrl | at_cal;

	// transfer completes on the cycle pready is high
	assign pready = psel & penable & ack_pending;
	assign pslverr = pready & err_q;
	assign prdata = prdata_q;
	assign xfer_done = pready;
	assign rd_done = xfer_done & ~pwrite;
	assign wr_done = xfer_done & pwrite & ~err_q;

	// command strobes, write-only and self clearing
	// clear command
	assign clear_cmd = wr_done & at_cmd & pstrb[0] &
		wbit(pwdata, rcc_pkg::CLEAR_BIT);
	assign cal_start = wr_done & at_cmd & pstrb[0] &
		wbit(pwdata, rcc_pkg::CAL_START_BIT);

	// freeze while addressed, from setup to the end of access
	// pulses in that span are lost, but the two bytes stay coherent
	// counter freeze
	assign count_frozen = psel & (at_high | at_low);
	assign mode_frozen = psel & at_mode;

	// two-stage synchronisers for the converter inputs
	// the two mode bits may resolve a cycle apart during a change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_meta_bus <= 2'h0;
			mode_sync <= 2'h0;
			pulse_meta <= 1'b0;
			pulse_sync <= 1'b0;
			pulse_prev <= 1'b0;
		end else begin
			mode_meta_bus <= rail_a_converter_mode;
			mode_sync <= mode_meta_bus;
			pulse_meta <= pfm_pulse;
			pulse_sync <= pulse_meta;
			pulse_prev <= pulse_sync;
		end
	end

	// rising edge of the synchronised pulse
	assign pulse_edge = pulse_sync & ~pulse_prev;

	// mode status register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_status <= rcc_pkg::MODE_RESET;
		end else if (mode_frozen) begin
			mode_status <= mode_status;
		end else if (cal_busy) begin
			mode_status <= cal_mode;
		end else begin
			mode_status <= mode_sync;
		end
	end

	// prescaler setting in the control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_sel <= rcc_pkg::PRESCALE_RESET;
		end else if (wr_done & at_ctrl & pstrb[0]) begin
			prescale_sel <= pwdata[rcc_pkg::PRESCALE_LSB +:
				rcc_pkg::PRESCALE_W];
		end
	end

	// pulses per count is two to the prescaler setting
	// the divisor tops out at 128, so eight bits hold it
	// prescaled count
	assign prescale_div = 8'h01 << prescale_sel;
	assign count_tick = pulse_edge & ~count_frozen &
		(prescale_cnt >= prescale_div - 8'h01);

	// prescaler; pulses seen while frozen are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_cnt <= 8'h00;
		end else if (clear_cmd) begin
			prescale_cnt <= 8'h00;
		end else if (pulse_edge & ~count_frozen) begin
			if (count_tick) begin
				prescale_cnt <= 8'h00;
			end else begin
				prescale_cnt <= prescale_cnt + 8'h01;
			end
		end
	end

	// sixteen-bit counter, clear wins over a tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= rcc_pkg::COUNT_RESET;
		end else if (clear_cmd) begin
			count <= rcc_pkg::COUNT_RESET;
		end else if (count_tick) begin
			count <= count + 16'h0001;
		end
	end

	// low byte shadow
	// the counter is frozen through the access, so both bytes agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shadow_low <= rcc_pkg::SHADOW_RESET;
		end else if (clear_cmd) begin
			shadow_low <= rcc_pkg::SHADOW_RESET;
		end else if (rd_done & at_high) begin
			shadow_low <= count[7:0];
		end
	end

	// calibration sequencer
	// a start while running is ignored; the window always runs out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_state <= rcc_pkg::RCC_CAL_IDLE;
			cal_timer <= 32'h00000000;
			cal_count <= 16'h0000;
			cal_mode <= rcc_pkg::MODE_RESET;
		end else begin
			unique case (cal_state)
				rcc_pkg::RCC_CAL_IDLE: begin
					if (cal_start) begin
						cal_mode <= mode_sync;
						cal_count <= 16'h0000;
						cal_timer <= 32'(CAL_CYCLES - 1);
						cal_state <= rcc_pkg::RCC_CAL_RUN;
					end
				end
				rcc_pkg::RCC_CAL_RUN: begin
					if (pulse_edge) begin
						cal_count <= cal_count + 16'h0001;
					end
					if (cal_timer == 32'h00000000) begin
						cal_state <= rcc_pkg::RCC_CAL_IDLE;
					end else begin
						cal_timer <= cal_timer - 32'h00000001;
					end
				end
				default: begin
					cal_state <= rcc_pkg::RCC_CAL_IDLE;
				end
			endcase
		end
	end

	assign cal_busy = (cal_state == rcc_pkg::RCC_CAL_RUN);

	// hold request to the converter, from a flip-flop so the pin is clean
	// force mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_hold <= 1'b0;
		end else if (cal_state == rcc_pkg::RCC_CAL_IDLE) begin
			mode_hold <= cal_start;
		end else if (~cal_busy | (cal_timer == 32'h00000000)) begin
			mode_hold <= 1'b0;
		end
	end
	assign mode_hold_value = cal_mode;

	// read mux, captured in the first access cycle
	always_comb begin
		next_prdata = 32'h00000000;
		next_err = ~mapped;
		if (at_mode) begin
			next_prdata[rcc_pkg::MODE_LSB +: rcc_pkg::MODE_W] =
				mode_status;
		end else if (at_high) begin
			next_prdata[7:0] = count[15:8];
		end else if (at_low) begin
			next_prdata[7:0] = shadow_low;
		end else if (at_ctrl) begin
			next_prdata[rcc_pkg::PRESCALE_LSB +: rcc_pkg::PRESCALE_W] =
				prescale_sel;
		end else if (at_cal) begin
			next_prdata[rcc_pkg::CAL_COUNT_LSB +: 16] = cal_count;
			next_prdata[rcc_pkg::CAL_MODE_LSB +: 2] = cal_mode;
			next_prdata[rcc_pkg::CAL_BUSY_BIT] = cal_busy;
		end
		// writes to read-only registers are refused
		if (pwrite & (at_mode | at_high | at_low | at_cal)) begin
			next_err = 1'b1;
		end
		if (pwrite) begin
			next_prdata = 32'h00000000;
		end
	end

	// one wait state, then pready
	// data captured in the first access cycle stays put while pready stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_pending <= 1'b0;
			prdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end else if (psel & penable & ~ack_pending) begin
			ack_pending <= 1'b1;
			prdata_q <= next_prdata;
			err_q <= next_err;
		end else if (xfer_done) begin
			ack_pending <= 1'b0;
			err_q <= 1'b0;
		end
	end

endmodule : rcc_readout
`default_nettype wire

// ==== logic/rcc_pkg.sv ====
// constants for the rail a charge counter readout block
`default_nettype none
package rcc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] MODE_IDX = 8'h12;
	localparam logic [7:0] HIGH_IDX = 8'h13;
	localparam logic [7:0] LOW_IDX = 8'h14;
	localparam logic [7:0] CMD_IDX = 8'h20;
	localparam logic [7:0] CTRL_IDX = 8'h21;
	localparam logic [7:0] CAL_IDX = 8'h22;

	// mode status fields
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 2;
	localparam logic [1:0] MODE_RESET = 2'h0;

	// command bits, write-only
	localparam int CLEAR_BIT = 5;
	localparam int CAL_START_BIT = 4;

	// control fields
	localparam int PRESCALE_LSB = 0;
	localparam int PRESCALE_W = 3;
	localparam logic [2:0] PRESCALE_RESET = 3'h0;

	// calibration result fields
	localparam int CAL_COUNT_LSB = 0;
	localparam int CAL_MODE_LSB = 16;
	localparam int CAL_BUSY_BIT = 24;

	// counter reset values
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] SHADOW_RESET = 8'h00;

	// calibration window
	localparam int CAL_TIME_US = 1000;
	localparam int CLK_MHZ = 50;
	localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;

	// converter modes of the first output rail
	typedef enum logic [1:0] {
		RCC_MODE_STEP_DOWN = 2'h0,
		RCC_MODE_AUTO = 2'h1,
		RCC_MODE_STEP_UP = 2'h2,
		RCC_MODE_PARALLEL_LINEAR = 2'h3
	} rcc_mode_e;

	// calibration sequencer states
	typedef enum logic [1:0] {
		RCC_CAL_IDLE = 2'b01,
		RCC_CAL_RUN = 2'b10
	} rcc_cal_state_e;
endpackage : rcc_pkg
`default_nettype wire

// ==== tb/rcc_readout_asserts.sv ====
// concurrent checks on the charge counter readout ports
`timescale 1ns/1ps
`default_nettype none
module rcc_readout_asserts #(
	parameter int CAL_CYCLES = 20,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// converter side
	input wire logic [1:0] rail_a_converter_mode,
	input wire logic pfm_pulse,
	input wire logic mode_hold,
	input wire logic [1:0] mode_hold_value
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completing apb access
	wire logic done = psel && penable && pready;

	property p_high_byte;
		done && !pwrite && paddr == 12'h04c |-> prdata[31:8] == 24'h0;
	endproperty
	a_high_byte: assert property (p_high_byte)
		else $error("high byte read has upper bits set");
	property p_high_ro;
		done && pwrite && paddr == 12'h04c |-> pslverr;
	endproperty
	a_high_ro: assert property (p_high_ro)
		else $error("write to high byte not refused");
	property p_low_ro;
		done && pwrite && paddr == 12'h050 |-> pslverr;
	endproperty
	a_low_ro: assert property (p_low_ro)
		else $error("write to low byte not refused");
	property p_mode_ro;
		done && pwrite && paddr == 12'h048 |-> pslverr;
	endproperty
	a_mode_ro: assert property (p_mode_ro)
		else $error("write to mode status not refused");
	property p_cmd_wo;
		done && !pwrite && paddr == 12'h080 |-> prdata == 32'h0 && !pslverr;
	endproperty
	a_cmd_wo: assert property (p_cmd_wo)
		else $error("command read not zero");
	property p_cal_start;
		done && pwrite && paddr == 12'h080 && pwdata[4] && pstrb[0]
			&& !mode_hold |-> ##[1:2] mode_hold;
	endproperty
	a_cal_start: assert property (p_cal_start)
		else $error("calibration did not start");
	property p_hold_stable;
		mode_hold && $past(mode_hold) |-> $stable(mode_hold_value);
	endproperty
	a_hold_stable: assert property (p_hold_stable)
		else $error("held mode changed during calibration");
	property p_cal_ends;
		$rose(mode_hold) |-> ##[1:1000] !mode_hold;
	endproperty
	a_cal_ends: assert property (p_cal_ends)
		else $error("calibration never finished");
endmodule : rcc_readout_asserts
`default_nettype wire

// ==== tb/rcc_readout_tb_top.sv ====
// self-checking bench for the charge counter readout
`timescale 1ns/1ps
`default_nettype none
module rcc_readout_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pfm_pulse;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic pready, pslverr, mode_hold, er;
	logic [1:0] rail_a_converter_mode, mode_hold_value;
	int fail_count, check_count, cyc;

	// device with a short calibration window
	rcc_readout #(.CAL_CYCLES(20), .ADDR_W(12)) u_rcc_readout (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rail_a_converter_mode(rail_a_converter_mode),
		.pfm_pulse(pfm_pulse), .mode_hold(mode_hold),
		.mode_hold_value(mode_hold_value));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task finish_test;
		$display("checks %0d failures %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// one apb transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		// registers addressed only for this transfer
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc

	// converter pulses, two cycles high and two low
	task pulses(input int n);
		repeat (n) begin
			pfm_pulse <= 1'b1;
			repeat (2) @(posedge pclk);
			pfm_pulse <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		repeat (4) @(posedge pclk);
	endtask : pulses

	task t_reset;
		rdc(12'h04c, 32'h0);
		rdc(12'h050, 32'h0);
		rdc(12'h048, 32'h0);
	endtask : t_reset

	task t_modes;
		for (int m = 0; m < 4; m++) begin
			rail_a_converter_mode <= 2'(m);
			repeat (4) @(posedge pclk);
			rdc(12'h048, 32'(m));
		end
	endtask : t_modes

	task t_count;
		pulses(261);
		rdc(12'h04c, 32'h01);
		pulses(3);
		rdc(12'h050, 32'h05);
		rdc(12'h04c, 32'h01);
		rdc(12'h050, 32'h08);
	endtask : t_count

	// a pulse that lands while the low byte is addressed is lost
	task t_freeze;
		pfm_pulse <= 1'b1;
		rdc(12'h050, 32'h08);
		pfm_pulse <= 1'b0;
		repeat (4) @(posedge pclk);
		rdc(12'h04c, 32'h01);
		rdc(12'h050, 32'h08);
	endtask : t_freeze

	task t_clear_prescale;
		apb(1'b1, 12'h080, 32'h20);
		rdc(12'h04c, 32'h0);
		rdc(12'h050, 32'h0);
		apb(1'b1, 12'h084, 32'h2);
		pulses(8);
		rdc(12'h04c, 32'h0);
		rdc(12'h050, 32'h2);
	endtask : t_clear_prescale

	task t_refuse;
		apb(1'b1, 12'h04c, 32'hff);
		chk(32'(er), 32'h1);
		apb(1'b1, 12'h050, 32'hff);
		chk(32'(er), 32'h1);
		apb(1'b1, 12'h048, 32'h3);
		chk(32'(er), 32'h1);
		apb(1'b0, 12'h080, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk(32'(er), 32'h1);
		rdc(12'h04c, 32'h0);
		rdc(12'h050, 32'h2);
	endtask : t_refuse

	// reset in mid-run returns the registers to their reset values
	task t_midreset;
		rdc(12'h084, 32'h2);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(12'h084, 32'h0);
		rdc(12'h04c, 32'h0);
		rdc(12'h050, 32'h0);
	endtask : t_midreset

	task t_cal;
		apb(1'b1, 12'h080, 32'h10);
		@(negedge pclk);
		chk(32'(mode_hold), 32'h1);
		chk(32'(mode_hold_value), 32'h3);
		@(posedge pclk);
		rail_a_converter_mode <= 2'h0;
		pulses(2);
		rdc(12'h048, 32'h3);
		repeat (40) if (mode_hold) @(posedge pclk);
		chk(32'(mode_hold), 32'h0);
		apb(1'b0, 12'h088, 32'h0);
		chk(rd & 32'h0103_ffff, 32'h0003_0002);
		rdc(12'h048, 32'h0);
	endtask : t_cal

	initial begin
		{presetn, psel, penable, pwrite, pfm_pulse} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		rail_a_converter_mode = 2'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_modes();
		t_count();
		t_freeze();
		t_clear_prescale();
		t_refuse();
		t_midreset();
		t_cal();
		finish_test();
	end
endmodule : rcc_readout_tb_top

bind rcc_readout rcc_readout_asserts #(
	.CAL_CYCLES(CAL_CYCLES), .ADDR_W(ADDR_W)) u_rcc_readout_asserts (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rail_a_converter_mode(rail_a_converter_mode), .pfm_pulse(pfm_pulse),
	.mode_hold(mode_hold), .mode_hold_value(mode_hold_value));
`default_nettype wire
